// *** src/edac_host_consts.svh ***
`ifndef EDAC_HOST_CONSTS_SVH
`define EDAC_HOST_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_WDATA 8'h04
`define OFF_CHECK 8'h08
`define OFF_BMASK 8'h0c
`define OFF_DIAG 8'h10
`define OFF_RDATA 8'h14
`define OFF_CAP 8'h18
`define OFF_STAT 8'h1c
`define OFF_IMASK 8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_GO 0
`define CTRL_OP_LO 1
`define ST_DONE 0
`define ST_SERR 1
`define ST_MULTI_ERROR_FLAG_N 2
`define ST_BUSY 3
`define FLAGS_IDLE 2'h3
`define BMASK_RST 4'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 100
`define SETUP_NS 5
`define HOLD_NS 10
`define LATCH_NS 30
`define GEN_NS 32
`define CORR_NS 37
`define SYNC_LAT 4
`define WAIT_SETUP 4'((`SETUP_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_LAT)
`define WAIT_HOLD 4'((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define WAIT_LATCH 4'((`LATCH_NS + `CLK_NS - 1) / `CLK_NS)
`define WAIT_GEN 4'((`GEN_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_LAT)
`define WAIT_CORR 4'((`CORR_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_LAT)

`endif

// *** src/edac_host_pkg.sv ***
package edac_host_pkg;

	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_READ = 2'b01,
		OP_RMW = 2'b10,
		OP_DIAG = 2'b11
	} op_t;

	// Encoded as {mode_select_high, mode_select_low}
	typedef enum logic [1:0] {
		MODE_WRITE = 2'b00,
		MODE_DIAG = 2'b01,
		MODE_READ = 2'b10,
		MODE_CORRECT = 2'b11
	} mode_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_WR_GEN = 4'b0001,
		ST_RD_SETUP = 4'b0010,
		ST_RD_HOLD = 4'b0011,
		ST_CORR = 4'b0100,
		ST_LATCH = 4'b0101,
		ST_MODIFY = 4'b0110,
		ST_REGEN = 4'b0111,
		ST_DG_RUN = 4'b1000,
		ST_DONE = 4'b1001
	} fsm_t;

	typedef struct packed {
		fsm_t fsm;
		logic [3:0] cnt;
		op_t op;
		logic [31:0] wdata;
		logic [6:0] check;
		logic [3:0] bmask;
		logic [31:0] diag;
		logic [31:0] rdata;
		logic [6:0] cap;
		logic [1:0] flags_n;
		logic [2:0] stat;
		logic [2:0] imask;
		logic [31:0] rd;
		mode_t mode;
		logic [3:0] ben_n;
		logic cen_n;
		logic hold;
		logic [3:0] drv_d;
		logic drv_c;
		logic [31:0] dout;
	} host_state_t;

	typedef struct packed {
		logic [40:0] a;
		logic [40:0] b;
		logic [40:0] c;
		logic [40:0] q;
	} sync_state_t;

endpackage

// *** src/edac_pins_if.sv ***
`timescale 1ns/1ps
interface edac_pins_if;
	logic [31:0] data;
	logic [6:0] check;
	logic serr_n;
	logic multi_error_flag_n_n;
	modport src (output data, output check, output serr_n, output multi_error_flag_n_n);
	modport dst (input data, input check, input serr_n, input multi_error_flag_n_n);
endinterface

// *** src/edac_pin_sampler.sv ***
`timescale 1ns/1ps
module edac_pin_sampler (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [31:0] data_i,
	input wire logic [6:0] check_i,
	input wire logic serr_n_i,
	input wire logic multi_error_flag_n_n_i,
	edac_pins_if.src pins
);
	import edac_host_pkg::*;

	sync_state_t s;
	sync_state_t next_s;
	logic [40:0] agree;

	// ----------------------------------------
	// Three-stage capture, accept on agreement
	// ----------------------------------------
	always_comb begin
		next_s = s;
		agree = ~(s.b ^ s.c);
		next_s.a = {multi_error_flag_n_n_i, serr_n_i, check_i, data_i};
		next_s.b = s.a;
		next_s.c = s.b;
		next_s.q = (s.b & agree) | (s.q & ~agree);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign pins.data = s.q[31:0];
	assign pins.check = s.q[38:32];
	assign pins.serr_n = s.q[39];
	assign pins.multi_error_flag_n_n = s.q[40];
endmodule // edac_pin_sampler

// *** src/edac_host_ctrl.sv ***
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "edac_host_consts.svh"
module edac_host_ctrl #(
	parameter bit BYTE_CTRL = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	output logic mode_select_high_o,
	output logic mode_select_low_o,
	input wire logic [31:0] data_port_lines_i,
	output logic [31:0] data_port_lines_o,
	output logic [31:0] data_port_lines_oe_o,
	output logic [3:0] byte_drive_enable_n_o,
	output logic word_drive_enable_n_o,
	output logic output_latch_hold_o,
	input wire logic [6:0] check_syndrome_lines_i,
	output logic [6:0] check_syndrome_lines_o,
	output logic [6:0] check_syndrome_lines_oe_o,
	output logic check_drive_enable_n_o,
	input wire logic single_error_flag_n_i,
	input wire logic multi_error_flag_n_i
);
	import edac_host_pkg::*;

	host_state_t s;
	host_state_t next_s;
	logic [2:0] ev;
	logic go;
	op_t req_op;
	logic [31:0] ben_bits;

	edac_pins_if smp ();

	edac_pin_sampler u_sampler (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.data_i(data_port_lines_i),
		.check_i(check_syndrome_lines_i),
		.serr_n_i(single_error_flag_n_i),
		.multi_error_flag_n_n_i(multi_error_flag_n_i),
		.pins(smp.src)
	);

	// ----------------------------------------
	// Register port and sequencer
	// ----------------------------------------
	always_comb begin
		next_s = s;
		ev = 3'h0;
		next_s.rd = 32'h0;
		go = (s.fsm == ST_IDLE) && wr_i && (addr_i == `OFF_CTRL) && wdata_i[`CTRL_GO];
		req_op = op_t'(wdata_i[`CTRL_OP_LO +: 2]);
		if (req_op == OP_RMW && !BYTE_CTRL) begin
			req_op = OP_READ;
		end
		if (rd_i) begin
			unique case (addr_i)
				`OFF_WDATA: next_s.rd = s.wdata;
				`OFF_CHECK: next_s.rd = {25'h0, s.check};
				`OFF_BMASK: next_s.rd = {28'h0, s.bmask};
				`OFF_DIAG: next_s.rd = s.diag;
				`OFF_RDATA: next_s.rd = s.rdata;
				`OFF_CAP: next_s.rd = {23'h0, s.flags_n, s.cap};
				`OFF_STAT: next_s.rd = {28'h0, s.fsm != ST_IDLE, s.stat};
				`OFF_IMASK: next_s.rd = {29'h0, s.imask};
				default: next_s.rd = 32'h0;
			endcase
		end
		if (wr_i && s.fsm == ST_IDLE) begin
			unique case (addr_i)
				`OFF_WDATA: next_s.wdata = wdata_i;
				`OFF_CHECK: next_s.check = wdata_i[6:0];
				`OFF_BMASK: next_s.bmask = wdata_i[3:0];
				`OFF_DIAG: next_s.diag = wdata_i;
				`OFF_IMASK: next_s.imask = wdata_i[2:0];
				default: next_s.imask = s.imask;
			endcase
		end
		next_s.cnt = (s.cnt == 4'h0) ? 4'h0 : s.cnt - 4'h1;
		unique case (s.fsm)
			ST_IDLE: begin
				if (go) begin
					next_s.op = req_op;
					next_s.flags_n = `FLAGS_IDLE;
					next_s.ben_n = 4'hf;
					next_s.drv_d = 4'hf;
					next_s.dout = s.wdata;
					if (req_op == OP_WRITE) begin
						next_s.mode = MODE_WRITE;
						next_s.cen_n = 1'b0;
						next_s.drv_c = 1'b0;
						next_s.cnt = `WAIT_GEN;
						next_s.fsm = ST_WR_GEN;
					end else begin
						next_s.mode = MODE_READ;
						next_s.cen_n = 1'b1;
						next_s.drv_c = 1'b1;
						next_s.cnt = `WAIT_SETUP;
						next_s.fsm = ST_RD_SETUP;
					end
				end
			end
			ST_WR_GEN: begin
				if (s.cnt == 4'h0) begin
					next_s.cap = smp.check;
					next_s.fsm = ST_DONE;
				end
			end
			ST_RD_SETUP: begin
				if (s.cnt == 4'h0) begin
					next_s.flags_n = {smp.multi_error_flag_n_n, smp.serr_n};
					if (s.op == OP_DIAG) begin
						next_s.mode = MODE_DIAG;
					end else begin
						next_s.mode = MODE_CORRECT;
					end
					next_s.cnt = `WAIT_HOLD;
					next_s.fsm = ST_RD_HOLD;
				end
			end
			ST_RD_HOLD: begin
				if (s.cnt == 4'h0) begin
					if (s.op == OP_DIAG) begin
						next_s.drv_c = 1'b0;
						next_s.cen_n = 1'b0;
						next_s.dout = s.diag;
						next_s.cnt = `WAIT_GEN;
						next_s.fsm = ST_DG_RUN;
					end else begin
						next_s.drv_d = 4'h0;
						next_s.drv_c = 1'b0;
						next_s.ben_n = 4'h0;
						next_s.cen_n = 1'b0;
						next_s.cnt = `WAIT_CORR;
						next_s.fsm = ST_CORR;
					end
				end
			end
			ST_CORR: begin
				if (s.cnt == 4'h0) begin
					next_s.rdata = smp.data;
					next_s.cap = smp.check;
					if (s.op == OP_RMW) begin
						next_s.hold = 1'b1;
						next_s.cnt = `WAIT_LATCH;
						next_s.fsm = ST_LATCH;
					end else begin
						next_s.fsm = ST_DONE;
					end
				end
			end
			ST_LATCH: begin
				if (s.cnt == 4'h0) begin
					next_s.ben_n = s.bmask;
					next_s.drv_d = s.bmask;
					next_s.dout = s.wdata;
					next_s.cnt = `WAIT_SETUP;
					next_s.fsm = ST_MODIFY;
				end
			end
			ST_MODIFY: begin
				if (s.cnt == 4'h0) begin
					next_s.mode = MODE_WRITE;
					next_s.cnt = `WAIT_GEN;
					next_s.fsm = ST_REGEN;
				end
			end
			ST_REGEN: begin
				if (s.cnt == 4'h0) begin
					next_s.rdata = smp.data;
					next_s.cap = smp.check;
					next_s.fsm = ST_DONE;
				end
			end
			ST_DG_RUN: begin
				if (s.cnt == 4'h0) begin
					next_s.flags_n = {smp.multi_error_flag_n_n, smp.serr_n};
					next_s.cap = smp.check;
					next_s.rdata = smp.data;
					next_s.fsm = ST_DONE;
				end
			end
			ST_DONE: begin
				ev[`ST_DONE] = 1'b1;
				ev[`ST_SERR] = ~s.flags_n[0];
				ev[`ST_MULTI_ERROR_FLAG_N] = ~s.flags_n[1];
				next_s.mode = MODE_WRITE;
				next_s.ben_n = 4'hf;
				next_s.cen_n = 1'b1;
				next_s.drv_d = 4'h0;
				next_s.drv_c = 1'b0;
				next_s.hold = 1'b0;
				next_s.fsm = ST_IDLE;
			end
			default: next_s.fsm = ST_IDLE;
		endcase
		// Set beats a clear in the same cycle
		next_s.stat = ((rd_i && addr_i == `OFF_STAT) ? 3'h0 : s.stat) | ev;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.fsm <= ST_IDLE;
			s.flags_n <= `FLAGS_IDLE;
			s.bmask <= `BMASK_RST;
			s.ben_n <= 4'hf;
			s.cen_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign ben_bits[8*b +: 8] = {8{s.ben_n[b]}};
			assign data_port_lines_oe_o[8*b +: 8] = {8{s.drv_d[b]}};
		end
	endgenerate

	assign data_port_lines_o = s.dout;
	assign check_syndrome_lines_o = s.check;
	assign check_syndrome_lines_oe_o = {7{s.drv_c}};
	assign mode_select_high_o = s.mode[1];
	assign mode_select_low_o = s.mode[0];
	assign byte_drive_enable_n_o = s.ben_n;
	assign word_drive_enable_n_o = s.ben_n[0];
	assign check_drive_enable_n_o = s.cen_n;
	assign output_latch_hold_o = s.hold;
	assign rdata_o = s.rd;
	assign irq_o = |(s.stat & s.imask);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_read_to_correct;
		(s.mode == MODE_READ) ##1 (s.mode == MODE_CORRECT);
	endsequence

	sequence s_start;
		go;
	endsequence

	property p_write_pins;
		s.fsm == ST_WR_GEN |-> s.mode == MODE_WRITE && !check_drive_enable_n_o
			&& byte_drive_enable_n_o == 4'hf;
	endproperty
	a_write_pins: assert property (p_write_pins) else $error("write mode pins wrong");

	property p_read_apply;
		s.fsm == ST_RD_SETUP |-> s.mode == MODE_READ
			&& data_port_lines_oe_o == 32'hffffffff && check_syndrome_lines_oe_o == 7'h7f;
	endproperty
	a_read_apply: assert property (p_read_apply) else $error("read apply pins wrong");

	property p_data_no_clash;
		(data_port_lines_oe_o & ~ben_bits) == 32'h0;
	endproperty
	a_data_no_clash: assert property (p_data_no_clash) else $error("data lane fight");

	property p_check_no_clash;
		|check_syndrome_lines_oe_o |-> check_drive_enable_n_o;
	endproperty
	a_check_no_clash: assert property (p_check_no_clash) else $error("check line fight");

	property p_hold_after_correct;
		s_read_to_correct |-> (data_port_lines_oe_o == 32'hffffffff)[*2];
	endproperty
	a_hold_after_correct: assert property (p_hold_after_correct) else $error("hold too short");

	property p_latch_order;
		$rose(output_latch_hold_o) |-> s.mode == MODE_CORRECT
			&& $past(s.mode) == MODE_CORRECT && byte_drive_enable_n_o == 4'h0;
	endproperty
	a_latch_order: assert property (p_latch_order) else $error("latch rose out of order");

	property p_hold_through_regen;
		(s.fsm == ST_REGEN) |-> output_latch_hold_o && s.mode == MODE_WRITE;
	endproperty
	a_hold_through_regen: assert property (p_hold_through_regen) else $error("latch dropped");

	property p_diag_pins;
		s.fsm == ST_DG_RUN |-> s.mode == MODE_DIAG && check_syndrome_lines_oe_o == 7'h0
			&& data_port_lines_o == s.diag;
	endproperty
	a_diag_pins: assert property (p_diag_pins) else $error("diagnostic pins wrong");

	property p_error_event;
		(s.fsm == ST_DONE && !s.flags_n[1]) |=> s.stat[`ST_MULTI_ERROR_FLAG_N]
			&& (irq_o || !s.imask[`ST_MULTI_ERROR_FLAG_N]);
	endproperty
	a_error_event: assert property (p_error_event) else $error("multi error not recorded");

	property p_op_bounded;
		s_start |-> ##[1:30] (s.fsm == ST_DONE);
	endproperty
	a_op_bounded: assert property (p_op_bounded) else $error("operation did not finish");
endmodule // edac_host_ctrl

// *** bench/edac_code_pkg.sv ***
package edac_code_pkg;

	// ----------------------------------------
	// Check code: data bit i uses the i-th weight-3 column
	// ----------------------------------------
	function automatic logic [6:0] col(input int i);
		int n;
		n = 0;
		for (int v = 0; v < 128; v++) begin
			if ($countones(v[6:0]) == 3) begin
				if (n == i) return v[6:0];
				n++;
			end
		end
		return 7'h00;
	endfunction

	function automatic logic [6:0] gen(input logic [31:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 0; i < 32; i++) if (d[i]) c ^= col(i);
		return c;
	endfunction

	function automatic logic [31:0] fix(input logic [6:0] s);
		for (int i = 0; i < 32; i++) if (col(i) == s) return 32'h1 << i;
		return 32'h0;
	endfunction

	function automatic logic multi(input logic [6:0] s);
		return s != 7'h00 && $countones(s) != 1 && fix(s) == 32'h0;
	endfunction

endpackage

// *** bench/edac_device_model.sv ***
`timescale 1ns/1ps
module edac_device_model (
	input wire logic mode_select_high_i,
	input wire logic mode_select_low_i,
	input wire logic [3:0] byte_drive_enable_n_i,
	input wire logic output_latch_hold_i,
	input wire logic check_drive_enable_n_i,
	input wire logic [31:0] data_port_lines_i,
	input wire logic [6:0] check_syndrome_lines_i,
	output logic [31:0] data_port_lines_o,
	output logic [31:0] data_oe_o,
	output logic [6:0] check_syndrome_lines_o,
	output logic check_oe_o,
	output logic single_error_flag_n_o,
	output logic multi_error_flag_n_o
);
	import edac_code_pkg::*;
	logic cor;
	logic [31:0] dlat, olat, corr;
	logic [6:0] clat, syn;
	logic [3:0] be_n;
	// ----------------------------------------
	// Latches and correction
	// ----------------------------------------
	assign cor = mode_select_high_i & mode_select_low_i;
	assign be_n = byte_drive_enable_n_i;
	always_latch begin
		if (!cor) dlat <= data_port_lines_i;
		if (!mode_select_low_i) clat <= check_syndrome_lines_i;
	end
	assign syn = gen(dlat) ^ clat;
	assign corr = cor ? dlat ^ fix(syn) : dlat;
	always @(posedge output_latch_hold_i) olat <= corr;
	assign data_port_lines_o = output_latch_hold_i ? olat : corr;
	assign data_oe_o = {{8{~be_n[3]}}, {8{~be_n[2]}}, {8{~be_n[1]}}, {8{~be_n[0]}}};
	assign check_syndrome_lines_o = cor ? syn : (mode_select_low_i ? clat : gen(dlat));
	assign check_oe_o = ~check_drive_enable_n_i;
	assign single_error_flag_n_o = syn == 7'h00;
	assign multi_error_flag_n_o = ~multi(syn);
endmodule // edac_device_model

// *** bench/tb_edac_host_ctrl.sv ***
`timescale 1ns/1ps
`include "edac_host_consts.svh"
module tb_edac_host_ctrl;
	import edac_host_pkg::*;
	import edac_code_pkg::*;
	typedef struct packed {
		op_t op;
		logic [31:0] wd;
		logic [31:0] df;
		logic [6:0] cf;
		logic [3:0] bm;
		logic [31:0] dg;
	} row_t;
	logic ref_clk_i, resetn_i, wr_i, rd_i, irq_o, s_hi, s_lo, hold, cen_n, d_coe, serr_n, multi_error_flag_n_n;
	logic cyc = 1'b0;
	logic wen_n;
	logic [7:0] addr_i;
	logic [3:0] ben_n;
	logic [31:0] wdata_i, rdata_o, h_do, h_doe, d_do, d_doe, dwire, flt;
	logic [6:0] h_co, h_coe, d_co, cwire;
	int fail_count, num_checks;
	row_t rows [10] = '{
		'{OP_WRITE, 32'h0000_0000, 32'h0, 7'h00, 4'h1, 32'h0},
		'{OP_WRITE, 32'hffff_ffff, 32'h0, 7'h00, 4'h1, 32'h0},
		'{OP_READ, 32'h1234_5678, 32'h0, 7'h00, 4'h1, 32'h0},
		'{OP_READ, 32'h1234_5678, 32'h8000_0000, 7'h00, 4'h1, 32'h0},
		'{OP_READ, 32'h0f0f_0f0f, 32'h0, 7'h40, 4'h1, 32'h0},
		'{OP_READ, 32'h0f0f_0f0f, 32'h3, 7'h00, 4'h1, 32'h0},
		'{OP_RMW, 32'ha5a5_a5a5, 32'h8, 7'h00, 4'h5, 32'h0},
		'{OP_RMW, 32'ha5a5_a5a5, 32'h8, 7'h00, 4'ha, 32'h0},
		'{OP_DIAG, 32'h1234_5678, 32'h0, 7'h00, 4'h1, 32'h1234_5658},
		'{OP_DIAG, 32'h1234_5678, 32'h0, 7'h00, 4'h1, 32'h1234_567b}
	};
	// ----------------------------------------
	// Wire resolution, released lines flip every cycle
	// ----------------------------------------
	assign flt = cyc ? 32'haaaa_aaaa : 32'h5555_5555;
	assign dwire = (h_doe & h_do) | (~h_doe & d_doe & d_do) | (~h_doe & ~d_doe & flt);
	assign cwire = (h_coe & h_co) | (~h_coe & {7{d_coe}} & d_co)
		| (~h_coe & ~{7{d_coe}} & flt[6:0]);
	always @(posedge ref_clk_i) cyc <= ~cyc;
	always @(negedge ref_clk_i) begin
		if (resetn_i === 1'b1) chk("word enable", {31'h0, ben_n[0]}, {31'h0, wen_n});
	end
	edac_host_ctrl dut (
		.ref_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
		.mode_select_high_o(s_hi), .mode_select_low_o(s_lo), .data_port_lines_i(dwire),
		.data_port_lines_o(h_do), .data_port_lines_oe_o(h_doe), .byte_drive_enable_n_o(ben_n),
		.word_drive_enable_n_o(wen_n), .output_latch_hold_o(hold), .check_syndrome_lines_i(cwire),
		.check_syndrome_lines_o(h_co), .check_syndrome_lines_oe_o(h_coe),
		.check_drive_enable_n_o(cen_n), .single_error_flag_n_i(serr_n),
		.multi_error_flag_n_i(multi_error_flag_n_n)
	);
	edac_device_model edac (
		.mode_select_high_i(s_hi), .mode_select_low_i(s_lo), .byte_drive_enable_n_i(ben_n),
		.output_latch_hold_i(hold), .check_drive_enable_n_i(cen_n), .data_port_lines_i(dwire),
		.check_syndrome_lines_i(cwire), .data_port_lines_o(d_do), .data_oe_o(d_doe),
		.check_syndrome_lines_o(d_co), .check_oe_o(d_coe), .single_error_flag_n_o(serr_n),
		.multi_error_flag_n_o(multi_error_flag_n_n)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		q = rdata_o;
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 200) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk("irq", 32'h1, {31'h0, irq_o});
	endtask
	task automatic summarize;
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#3ms;
		fail_count++;
		$display("unexpected run time expected done seen hang");
		summarize;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		row_t r;
		logic [6:0] ck, syn;
		logic [31:0] corr, nw, q;
		{resetn_i, addr_i, wdata_i, wr_i, rd_i} = '0;
		repeat (19) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("pins", 32'h07c, {s_hi, s_lo, ben_n, cen_n, hold, irq_o});
		chk("oe", 32'h0, h_doe | {25'h0, h_coe});
		@(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(`OFF_BMASK, q);
		chk("bmask", {28'h0, `BMASK_RST}, q);
		wr(8'h24, 32'hffff_ffff);
		rd(8'h24, q);
		chk("unmapped", 32'h0, q);
		wr(`OFF_IMASK, 32'h1);
		foreach (rows[i]) begin
			r = rows[i];
			ck = gen(r.wd ^ r.df) ^ r.cf;
			wr(`OFF_WDATA, r.wd);
			wr(`OFF_CHECK, {25'h0, ck});
			wr(`OFF_BMASK, {28'h0, r.bm});
			wr(`OFF_DIAG, r.dg);
			wr(`OFF_CTRL, {29'h0, r.op, 1'b1});
			wait_irq;
			syn = gen(r.op == OP_DIAG ? r.dg : r.wd) ^ ck;
			corr = r.wd ^ fix(syn);
			for (int b = 0; b < 4; b++) nw[8*b +: 8] = r.bm[b] ? r.wd[8*b +: 8] : corr[8*b +: 8];
			rd(`OFF_STAT, q);
			chk("stat", {multi(syn) && r.op != OP_WRITE, syn != 7'h00 && r.op != OP_WRITE, 1'b1}, q);
			rd(`OFF_RDATA, q);
			if (r.op != OP_WRITE) chk("rdata", r.op == OP_DIAG ? r.dg : (r.op == OP_RMW ? nw : corr), q);
			rd(`OFF_CAP, q);
			chk("cap", r.op == OP_WRITE ? gen(r.wd) : r.op == OP_READ ? syn : r.op == OP_DIAG ? ck : gen(nw), {25'h0, q[6:0]});
			@(negedge ref_clk_i);
			chk("irq", 32'h0, {31'h0, irq_o});
		end
		wr(`OFF_WDATA, 32'h0000_00ff);
		wr(`OFF_CTRL, 32'h1);
		wr(`OFF_WDATA, 32'hffff_0000);
		wait_irq;
		rd(`OFF_CAP, q);
		chk("busy write", {25'h0, gen(32'h0000_00ff)}, {25'h0, q[6:0]});
		rd(`OFF_STAT, q);
		wr(`OFF_IMASK, 32'h0);
		wr(`OFF_CTRL, 32'h1);
		repeat (60) @(posedge ref_clk_i);
		chk("masked irq", 32'h0, {31'h0, irq_o});
		wr(`OFF_IMASK, 32'h1);
		wait_irq;
		rd(`OFF_STAT, q);
		chk("stat", 32'h1, q);
		rd(`OFF_STAT, q);
		chk("stat cleared", 32'h0, q);
		@(negedge ref_clk_i);
		chk("irq", 32'h0, {31'h0, irq_o});
		// ----------------------------------------
		// Reset in the middle of a byte write
		// ----------------------------------------
		wr(`OFF_BMASK, 32'h6);
		wr(`OFF_CTRL, 32'h5);
		repeat (20) @(posedge ref_clk_i);
		resetn_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("reset pins", 32'h07c, {s_hi, s_lo, ben_n, cen_n, hold, irq_o});
		chk("reset oe", 32'h0, h_doe | {25'h0, h_coe});
		@(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(`OFF_STAT, q);
		chk("reset stat", 32'h0, q);
		rd(`OFF_BMASK, q);
		chk("reset bmask", {28'h0, `BMASK_RST}, q);
		wr(`OFF_IMASK, 32'h1);
		wr(`OFF_WDATA, 32'h8000_0001);
		wr(`OFF_CTRL, 32'h1);
		wait_irq;
		rd(`OFF_CAP, q);
		chk("write after reset", {25'h0, gen(32'h8000_0001)}, {25'h0, q[6:0]});
		summarize;
	end
endmodule // tb_edac_host_ctrl
